// [rtl/rxsw_pkg.sv]
// constants and types for the receive status word builder
package rxsw_pkg;

  // register byte offsets on the wishbone port
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STAT      = 8'h04;
  localparam logic [7:0]  REG_LAST_WORD = 8'h08;
  localparam logic [7:0]  REG_FRAMES    = 8'h0c;

  // control register fields and reset value
  localparam int          CTRL_RX_EN_POS    = 2;
  localparam int          CTRL_PASS_BAD_POS = 16;
  localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;

  // status register fields, fault bit is write-one-to-clear
  localparam int          STAT_FAULT_POS   = 0;
  localparam int          STAT_HALTED_POS  = 1;
  localparam int          STAT_IN_FRAME_POS = 2;

  // receive status word field positions
  localparam int          SW_FILTER_FAIL_POS = 30;
  localparam int          SW_LEN_LSB         = 16;
  localparam int          SW_LEN_W           = 14;
  localparam int          SW_ERR_SUM_POS     = 15;
  localparam int          SW_BCAST_POS       = 13;
  localparam int          SW_LEN_MISM_POS    = 12;
  localparam int          SW_RUNT_POS        = 11;
  localparam int          SW_MCAST_POS       = 10;
  localparam int          SW_TOO_LONG_POS    = 7;
  localparam int          SW_LATE_COL_POS    = 6;
  localparam int          SW_FRAME_TYPE_POS  = 5;
  localparam int          SW_WDOG_POS        = 4;
  localparam int          SW_MII_ERR_POS     = 3;
  localparam int          SW_DRIBBLE_POS     = 2;
  localparam int          SW_CRC_POS         = 1;

  // frame length limits in bytes
  localparam logic [13:0] MIN_FRAME_BYTES    = 14'd64;
  localparam logic [13:0] MAX_FRAME_BYTES    = 14'd1518;
  localparam logic [15:0] MAX_LEN_FIELD      = 16'd1500;
  localparam logic [13:0] MIN_TYPE_BYTES     = 14'd14;
  localparam logic [13:0] WDOG_BYTES         = 14'd2048;
  localparam logic [13:0] HDR_FCS_BYTES      = 14'd18;
  localparam logic [15:0] MIN_PAYLOAD        = 16'd46;
  localparam logic [13:0] BYTE_CNT_MAX       = 14'h3fff;

  // header byte positions
  localparam logic [13:0] DA_LAST_IDX        = 14'd5;
  localparam logic [13:0] LT_HI_IDX          = 14'd12;
  localparam logic [13:0] LT_LO_IDX          = 14'd13;

  // dribble thresholds
  localparam logic [2:0]  DRIB_MII_BITS      = 3'd4;
  localparam logic [2:0]  DRIB_10M_BITS      = 3'd3;

  typedef enum logic [1:0] {
    RXSW_IDLE,
    RXSW_FRAME,
    RXSW_WAIT_DATA
  } rxsw_state_t;

endpackage : rxsw_pkg

// [rtl/rxsw_core.sv]
// receive status word builder with receiver stop and fault flag
//
// Register access over Wishbone and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module rxsw_core
  import rxsw_pkg::*;
(
  // clock, reset, enable
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        ce,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // frame events from the mac receive logic
  input  wire logic        rx_start,
  input  wire logic        rx_byte_vld,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_mii_err,
  input  wire logic        rx_late_col,
  input  wire logic        rx_end,
  input  wire logic        rx_crc_bad,
  input  wire logic [2:0]  rx_dribble,
  input  wire logic        rx_filter_fail,
  input  wire logic        mode_10m,
  input  wire logic        rx_data_done,
  // status fifo write side and fifo fault events
  output logic             sfifo_push,
  output logic      [31:0] sfifo_word,
  input  wire logic        sfifo_full,
  input  wire logic        dfifo_underrun,
  input  wire logic        sfifo_underrun,
  // receiver state
  output logic             receiver_halted_event,
  output logic             receive_fault_flag,
  output logic             rx_running
);

  // frame group state
  rxsw_state_t state;
  rxsw_state_t next_state;
  logic [13:0] byte_cnt;
  logic [13:0] next_byte_cnt;
  logic [15:0] len_field;
  logic [15:0] next_len_field;
  logic        bcast;
  logic        next_bcast;
  logic        mcast;
  logic        next_mcast;
  logic        mii_err;
  logic        next_mii_err;
  logic        late_col;
  logic        next_late_col;
  logic        crc_bad;
  logic        next_crc_bad;
  logic        filt_fail;
  logic        next_filt_fail;
  logic [2:0]  dribble;
  logic [2:0]  next_dribble;
  logic        next_sfifo_push;
  logic [31:0] next_sfifo_word;
  logic        next_rx_running;
  logic        next_halted_event;
  logic        overrun;

  // bus group state
  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic        next_fault;
  logic [31:0] last_word;
  logic [31:0] next_last_word;
  logic [15:0] frames;
  logic [15:0] next_frames;
  logic        next_ack;
  logic [31:0] next_dat;

  // status word helpers and control fields
  logic        rx_enable;
  logic        pass_bad;
  logic [31:0] word;
  logic        runt;
  logic        too_long;
  logic        len_mism;
  logic [13:0] payload;
  logic        da_seen;

  // control fields that steer the receiver
  assign rx_enable = ctrl[CTRL_RX_EN_POS];
  assign pass_bad  = ctrl[CTRL_PASS_BAD_POS];

  // dribble test: exactly four bits on mii, three or more at 10 Mbps
  function automatic logic rxsw_dribble_hit(
    input logic [2:0] bits,
    input logic       slow_mode
  );
    if (slow_mode) begin
      return bits >= DRIB_10M_BITS;
    end
    return bits == DRIB_MII_BITS;
  endfunction : rxsw_dribble_hit

  // byte-lane merge of a wishbone write into a stored word
  function automatic logic [31:0] rxsw_lane_merge(
    input logic [31:0] old_word,
    input logic [31:0] new_word,
    input logic [3:0]  sel
  );
    logic [31:0] merged;
    merged = old_word;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        merged[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    return merged;
  endfunction : rxsw_lane_merge

  // status word assembly from the collected frame facts
  always_comb begin
    runt     = byte_cnt < MIN_FRAME_BYTES;
    too_long = byte_cnt > MAX_FRAME_BYTES;
    payload  = byte_cnt - HDR_FCS_BYTES;
    da_seen  = byte_cnt > DA_LAST_IDX;
    // short frames are padded, so a length field below 46 is checked against a 64-byte frame
    if (len_field > MAX_LEN_FIELD || byte_cnt < MIN_TYPE_BYTES) begin
      len_mism = 1'b0;
    end else if (len_field < MIN_PAYLOAD) begin
      len_mism = byte_cnt != MIN_FRAME_BYTES;
    end else begin
      len_mism = {2'b00, payload} != len_field;
    end
    word = 32'h0000_0000;
    word[SW_FILTER_FAIL_POS] = filt_fail;
    word[SW_LEN_LSB +: SW_LEN_W] = byte_cnt;
    word[SW_BCAST_POS] = bcast && da_seen;
    word[SW_LEN_MISM_POS] = len_mism;
    word[SW_RUNT_POS] = runt;
    word[SW_MCAST_POS] = mcast && !(bcast && da_seen);
    word[SW_TOO_LONG_POS] = too_long;
    word[SW_LATE_COL_POS] = late_col;
    word[SW_FRAME_TYPE_POS] = (len_field > MAX_LEN_FIELD)
                              && (byte_cnt >= MIN_TYPE_BYTES);
    word[SW_WDOG_POS] = byte_cnt > WDOG_BYTES;
    word[SW_MII_ERR_POS] = mii_err;
    word[SW_DRIBBLE_POS] = !late_col
                           && rxsw_dribble_hit(dribble, mode_10m);
    word[SW_CRC_POS] = crc_bad || mii_err;
    word[SW_ERR_SUM_POS] = word[SW_RUNT_POS] | word[SW_TOO_LONG_POS]
                         | word[SW_LATE_COL_POS]
                         | word[SW_CRC_POS];
  end

  // frame sequencing, receiver halt and status push
  always_comb begin
    next_state        = state;
    next_byte_cnt     = byte_cnt;
    next_len_field    = len_field;
    next_bcast        = bcast;
    next_mcast        = mcast;
    next_mii_err      = mii_err;
    next_late_col     = late_col;
    next_crc_bad      = crc_bad;
    next_filt_fail    = filt_fail;
    next_dribble      = dribble;
    next_sfifo_push   = 1'b0;
    next_sfifo_word   = sfifo_word;
    next_rx_running   = rx_running;
    next_halted_event = 1'b0;
    overrun           = 1'b0;
    case (state)
      RXSW_IDLE: begin
        if (!rx_running) begin
          next_rx_running = rx_enable;
        end else if (!rx_enable) begin
          // halt only between frames, one pulse per stop
          next_rx_running   = 1'b0;
          next_halted_event = 1'b1;
        end else if (rx_start) begin
          next_state     = RXSW_FRAME;
          next_byte_cnt  = 14'd0;
          next_len_field = 16'h0000;
          next_bcast     = 1'b1;
          next_mcast     = 1'b0;
          next_mii_err   = 1'b0;
          next_late_col  = 1'b0;
        end
      end
      RXSW_FRAME: begin
        if (rx_byte_vld) begin
          // count saturates, the frame itself is never cut short
          if (byte_cnt != BYTE_CNT_MAX) begin
            next_byte_cnt = byte_cnt + 14'd1;
          end
          if (byte_cnt <= DA_LAST_IDX && rx_byte != 8'hff) begin
            next_bcast = 1'b0;
          end
          if (byte_cnt == 14'd0) begin
            next_mcast = rx_byte[0];
          end
          if (byte_cnt == LT_HI_IDX) begin
            next_len_field[15:8] = rx_byte;
          end
          if (byte_cnt == LT_LO_IDX) begin
            next_len_field[7:0] = rx_byte;
          end
        end
        if (rx_mii_err) begin
          next_mii_err = 1'b1;
        end
        if (rx_late_col) begin
          next_late_col = 1'b1;
        end
        if (rx_end) begin
          next_crc_bad   = rx_crc_bad;
          next_dribble   = rx_dribble;
          next_filt_fail = rx_filter_fail;
          next_state     = RXSW_WAIT_DATA;
        end
      end
      RXSW_WAIT_DATA: begin
        // hold the word back until the data fifo has the whole frame
        if (rx_data_done) begin
          next_state = RXSW_IDLE;
          if (runt && !pass_bad) begin
            next_sfifo_push = 1'b0;
          end else if (sfifo_full) begin
            overrun = 1'b1;
          end else begin
            next_sfifo_push = 1'b1;
            next_sfifo_word = word;
          end
        end
      end
      default: begin
        next_state = RXSW_IDLE;
      end
    endcase
  end

  // frame group registers
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state                 <= RXSW_IDLE;
      byte_cnt              <= 14'd0;
      len_field             <= 16'h0000;
      bcast                 <= 1'b0;
      mcast                 <= 1'b0;
      mii_err               <= 1'b0;
      late_col              <= 1'b0;
      crc_bad               <= 1'b0;
      filt_fail             <= 1'b0;
      dribble               <= 3'd0;
      sfifo_push            <= 1'b0;
      sfifo_word            <= 32'h0000_0000;
      rx_running            <= 1'b0;
      receiver_halted_event <= 1'b0;
    end else if (ce) begin
      state                 <= next_state;
      byte_cnt              <= next_byte_cnt;
      len_field             <= next_len_field;
      bcast                 <= next_bcast;
      mcast                 <= next_mcast;
      mii_err               <= next_mii_err;
      late_col              <= next_late_col;
      crc_bad               <= next_crc_bad;
      filt_fail             <= next_filt_fail;
      dribble               <= next_dribble;
      sfifo_push            <= next_sfifo_push;
      sfifo_word            <= next_sfifo_word;
      rx_running            <= next_rx_running;
      receiver_halted_event <= next_halted_event;
    end
  end

  // wishbone decode, control writes, fault flag and counters
  always_comb begin
    next_ctrl      = ctrl;
    next_last_word = last_word;
    next_frames    = frames;
    next_fault     = receive_fault_flag;
    next_ack       = 1'b0;
    next_dat       = wb_dat_o;
    if (next_sfifo_push) begin
      next_last_word = next_sfifo_word;
      next_frames    = frames + 16'd1;
    end
    if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
      next_ack = 1'b1;
      next_dat = 32'h0000_0000;
      if (wb_we_i) begin
        if (wb_adr_i == REG_CTRL) begin
          next_ctrl = rxsw_lane_merge(ctrl, wb_dat_i, wb_sel_i);
        end
        if (wb_adr_i == REG_STAT && wb_sel_i[0]
            && wb_dat_i[STAT_FAULT_POS]) begin
          next_fault = 1'b0;
        end
      end else begin
        case (wb_adr_i)
          REG_CTRL: begin
            next_dat = ctrl;
          end
          REG_STAT: begin
            next_dat[STAT_FAULT_POS]    = receive_fault_flag;
            next_dat[STAT_HALTED_POS]   = !rx_running;
            next_dat[STAT_IN_FRAME_POS] = state != RXSW_IDLE;
          end
          REG_LAST_WORD: begin
            next_dat = last_word;
          end
          REG_FRAMES: begin
            next_dat = {16'h0000, frames};
          end
          default: begin
            next_dat = 32'h0000_0000;
          end
        endcase
      end
    end
    // a fault event in the clearing cycle wins; reception goes on
    if (dfifo_underrun || sfifo_underrun || overrun) begin
      next_fault = 1'b1;
    end
  end

  // bus group registers
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ctrl               <= CTRL_RESET;
      last_word          <= 32'h0000_0000;
      frames             <= 16'h0000;
      receive_fault_flag <= 1'b0;
      wb_ack_o           <= 1'b0;
      wb_dat_o           <= 32'h0000_0000;
    end else if (ce) begin
      ctrl               <= next_ctrl;
      last_word          <= next_last_word;
      frames             <= next_frames;
      receive_fault_flag <= next_fault;
      wb_ack_o           <= next_ack;
      wb_dat_o           <= next_dat;
    end
  end

endmodule : rxsw_core

`default_nettype wire

// [verification/rxsw_core_sva.sv]
// port assertions for the receive status word builder
`timescale 1ns/1ps
`default_nettype none
module rxsw_core_sva (
  // clock, reset, enable
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        ce,
  // bus handshake
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  // status word and receiver state
  input wire logic        sfifo_push,
  input wire logic [31:0] sfifo_word,
  input wire logic        dfifo_underrun,
  input wire logic        sfifo_underrun,
  input wire logic        receiver_halted_event,
  input wire logic        receive_fault_flag,
  input wire logic        rx_running
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // bus answer and status word checks
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce
    |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o && ce |=> !wb_ack_o)
    else $error("ack too long");
  a_rsvd_zero: assert property (sfifo_push |-> !sfifo_word[31] &&
    !sfifo_word[14] && sfifo_word[9:8] == 2'h0 && !sfifo_word[0])
    else $error("reserved bit set");
  a_err_sum: assert property (sfifo_push |-> sfifo_word[15] ==
    (sfifo_word[11] | sfifo_word[7] | sfifo_word[6] | sfifo_word[1]))
    else $error("error summary wrong");
  a_drib_late: assert property (sfifo_push && sfifo_word[6]
    |-> !sfifo_word[2]) else $error("dribble with late collision");
  a_type_runt: assert property (sfifo_push &&
    sfifo_word[29:16] < 14'h000e |-> !sfifo_word[5])
    else $error("frame type on short runt");
  a_wdog_long: assert property (sfifo_push && sfifo_word[4]
    |-> sfifo_word[7]) else $error("watchdog without too long");
  // receiver stop and fault flag
  a_halt_stop: assert property (receiver_halted_event
    |-> !rx_running && $past(rx_running)) else $error("halt event bad");
  a_halt_pulse: assert property (receiver_halted_event && ce
    |=> !receiver_halted_event) else $error("halt event too long");
  a_under_fault: assert property (ce && (dfifo_underrun
    || sfifo_underrun) |=> receive_fault_flag)
    else $error("fault flag not set");
endmodule : rxsw_core_sva
bind rxsw_core rxsw_core_sva u_sva (.mclk(mclk), .nrst(nrst), .ce(ce),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .sfifo_push(sfifo_push), .sfifo_word(sfifo_word),
  .dfifo_underrun(dfifo_underrun), .sfifo_underrun(sfifo_underrun),
  .receiver_halted_event(receiver_halted_event),
  .receive_fault_flag(receive_fault_flag), .rx_running(rx_running));
`default_nettype wire

// [verification/rxsw_sfifo_model.sv]
// two-deep status fifo model standing at the block's write side
`timescale 1ns/1ps
`default_nettype none
module rxsw_sfifo_model (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // write side from the block, read side from the host
  input  wire logic        push,
  input  wire logic [31:0] word,
  input  wire logic        pop,
  output logic             full,
  output logic             underrun,
  output logic      [31:0] head
);
  logic [31:0] mem [2];
  logic [1:0]  cnt;
  assign full = cnt == 2'h2;
  assign head = mem[0];
  // store words, shift on pop, flag a pop from empty
  always_ff @(posedge mclk) begin
    underrun <= pop && cnt == 2'h0;
    if (!nrst) begin
      cnt <= 2'h0;
    end else if (pop && cnt != 2'h0) begin
      mem[0] <= mem[1];
      cnt <= cnt - 2'h1;
    end else if (push && !full) begin
      mem[cnt[0]] <= word;
      cnt <= cnt + 2'h1;
    end
  end
endmodule : rxsw_sfifo_model
`default_nettype wire

// [verification/rxsw_core_tb_top.sv]
// self-checking bench for the receive status word builder
`timescale 1ns/1ps
`default_nettype none
module rxsw_core_tb_top;
  import rxsw_pkg::*;
  logic        mclk = 1'b0, nrst = 1'b0, ce = 1'b1, cyc = 1'b0, stb = 1'b0;
  logic        we = 1'b0, st = 1'b0, vld = 1'b0, mii = 1'b0, late = 1'b0;
  logic        fin = 1'b0, crc = 1'b0, ff = 1'b0, m10 = 1'b0, done = 1'b0;
  logic        pop = 1'b0, dund = 1'b0;
  logic [7:0]  adr = 8'h00, byt = 8'h00;
  logic [2:0]  drb = 3'h0;
  logic [31:0] dat = 32'h0, q;
  wire logic   ack, push, full, sund, halt, fault, run;
  wire logic [31:0] rdat, word, head;
  int          n_mismatch = 0, check_count = 0, n_push = 0, n_halt = 0;
  int          n_exp = 0, h0;
  bit          pass_bad = 1'b0;
  int          tn [10] = '{64, 1519, 2049, 64, 120, 100, 100, 100, 20, 12};
  logic [4:0]  te [10] = '{5'h0, 5'h0, 5'h0, 5'h0, 5'h0, 5'h11, 5'h02,
                           5'h0c, 5'h0, 5'h0};
  logic [2:0]  tdr [10] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h4, 3'h4,
                            3'h3, 3'h0, 3'h0};
  rxsw_core u_rxsw_core (.mclk(mclk), .nrst(nrst), .ce(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .rx_start(st), .rx_byte_vld(vld), .rx_byte(byt), .rx_mii_err(mii),
    .rx_late_col(late), .rx_end(fin), .rx_crc_bad(crc), .rx_dribble(drb),
    .rx_filter_fail(ff), .mode_10m(m10), .rx_data_done(done),
    .sfifo_push(push), .sfifo_word(word), .sfifo_full(full),
    .dfifo_underrun(dund), .sfifo_underrun(sund),
    .receiver_halted_event(halt), .receive_fault_flag(fault),
    .rx_running(run));
  rxsw_sfifo_model u_rxsw_sfifo_model (.mclk(mclk), .nrst(nrst),
    .push(push), .word(word), .pop(pop), .full(full), .underrun(sund),
    .head(head));
  // clock, event counters and hang guard
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    n_push += int'(push === 1'b1);
    n_halt += int'(halt === 1'b1);
  end
  initial begin
    repeat (60000) @(posedge mclk);
    n_mismatch++;
    finish_test();
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  // one classic bus cycle, held until ack is seen
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    {cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (ack !== 1'b1 && i < 20);
    if (ack !== 1'b1) n_mismatch++;
    if (ack !== 1'b1) finish_test();
    q = rdat;
    {cyc, stb, we} <= 3'h0;
    @(posedge mclk);
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e, string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask : rd
  task automatic pulse_pop();
    pop <= 1'b1;
    tick(1);
    pop <= 1'b0;
    tick(1);
  endtask : pulse_pop
  function automatic logic [7:0] fda(input int k);
    return k == 0 ? 8'hff : (k == 1 ? 8'h01 : 8'h02);
  endfunction : fda
  function automatic logic [15:0] flt(input int k);
    return k == 3 ? 16'h002e : (k == 4 ? 16'h0064 : 16'h0800);
  endfunction : flt
  // expected status word of table entry k
  function automatic logic [31:0] exp_word(input int k);
    logic [31:0] w;
    logic [13:0] c;
    logic [15:0] lt;
    c = tn[k][13:0];
    lt = flt(k);
    w = 32'h0;
    w[30] = te[k][4];
    w[29:16] = c;
    w[13] = fda(k) == 8'hff;
    w[10] = fda(k) == 8'h01;
    w[12] = lt <= 16'h05dc && c >= 14'h000e &&
            (lt < 16'h002e ? c != 14'h0040 : {2'h0, c} - 16'h0012 != lt);
    w[11] = c < 14'h0040;
    w[7] = c > 14'h05ee;
    w[6] = te[k][1];
    w[5] = lt > 16'h05dc && c >= 14'h000e;
    w[4] = c > 14'h0800;
    w[3] = te[k][0];
    w[2] = !te[k][1] && (te[k][3] ? tdr[k] >= 3'h3 : tdr[k] == 3'h4);
    w[1] = te[k][2] | te[k][0];
    w[15] = w[11] | w[7] | w[6] | w[1];
    return w;
  endfunction : exp_word
  // one frame from the mac side, data done three cycles after its end
  task automatic send(input int k);
    int i, p0;
    bit ep;
    ep = (tn[k] >= 64 || pass_bad) && full !== 1'b1 && run === 1'b1;
    p0 = n_push;
    st <= 1'b1;
    @(posedge mclk);
    st <= 1'b0;
    for (i = 0; i < tn[k]; i++) begin
      {vld, fin, mii, late} <= {1'b1, i == tn[k] - 1, te[k][0] && i == 3,
                                te[k][1] && i == tn[k] / 2};
      {crc, m10, ff, drb} <= {te[k][2], te[k][3], te[k][4], tdr[k]};
      byt <= i < 6 ? fda(k) : 8'(i == 12 ? flt(k) >> 8 : flt(k));
      @(posedge mclk);
    end
    {vld, fin, mii, late} <= 4'h0;
    tick(3);
    chk("early push", n_push - p0, 0);
    done <= 1'b1;
    tick(1);
    done <= 1'b0;
    tick(3);
    chk("push count", n_push - p0, ep);
    if (ep) chk("word", word, exp_word(k));
    n_exp += ep;
  endtask : send
  // reset, frame table, fifo faults, stop and restart
  initial begin
    tick(8);
    nrst <= 1'b1;
    tick(1);
    rd(REG_CTRL, CTRL_RESET, "ctrl reset");
    rd(REG_STAT, 32'h2, "stat reset");
    rd(8'h10, 32'h0, "unmapped");
    wb(1'b1, REG_CTRL, 32'h4);
    tick(2);
    chk("running", run, 1'b1);
    $display("test reset done");
    for (int k = 0; k < 10; k++) begin
      if (k == 9) wb(1'b1, REG_CTRL, 32'h0001_0004);
      pass_bad = k == 9;
      send(k);
      if (k != 8) chk("head", head, exp_word(k));
      if (k != 8) rd(REG_LAST_WORD, exp_word(k), "last");
      if (k != 8) pulse_pop();
    end
    $display("test frame table done");
    repeat (3) send(0);
    rd(REG_STAT, 32'h1, "overrun fault");
    chk("fault pin", fault, 1'b1);
    wb(1'b1, REG_STAT, 32'h1);
    repeat (3) pulse_pop();
    rd(REG_STAT, 32'h1, "underrun fault");
    wb(1'b1, REG_STAT, 32'h1);
    rd(REG_STAT, 32'h0, "fault cleared");
    // a frozen block ignores a fault event
    ce <= 1'b0;
    dund <= 1'b1;
    tick(1);
    {ce, dund} <= 2'h2;
    tick(1);
    chk("frozen fault", fault, 1'b0);
    dund <= 1'b1;
    tick(1);
    dund <= 1'b0;
    rd(REG_STAT, 32'h1, "data underrun");
    send(5);
    // soft reset after the underrun, then enable again
    nrst <= 1'b0;
    tick(2);
    nrst <= 1'b1;
    tick(1);
    n_exp = 0;
    pass_bad = 1'b0;
    rd(REG_STAT, 32'h2, "soft reset stat");
    rd(REG_FRAMES, 32'h0, "soft reset frames");
    wb(1'b1, REG_CTRL, 32'h4);
    tick(2);
    chk("running again", run, 1'b1);
    $display("test fifo faults done");
    h0 = n_halt;
    wb(1'b1, REG_CTRL, 32'h0);
    tick(4);
    chk("halt events", n_halt - h0, 1);
    chk("stopped", run, 1'b0);
    send(0);
    wb(1'b1, REG_CTRL, 32'h4);
    tick(2);
    chk("restarted", run, 1'b1);
    send(3);
    rd(REG_FRAMES, n_exp, "frames");
    $display("test stop restart done");
    finish_test();
  end
endmodule : rxsw_core_tb_top
`default_nettype wire
